// [vpic_ctrl.sv]
// Purpose: vectored, maskable priority interrupt controller, APB slave
// Assumes: clk runs continuously; peripheral lines are on clk
// Notes:   zero-wait APB; read data captured in the setup cycle
//
// Behaviour
// RL1 - source 0 comes from the fast request pin only
// RL2 - source 1 is the OR of all system peripheral lines
// RL3 - sources 2-31 take a peripheral line or an external line
// RL4 - peripheral identifier equals the source number it drives
// RL5 - every source has its own mode register with trigger type
// RL6 - internal sources selectable level or edge, polarity irrelevant
// RL7 - external sources: high level, low level, rising or falling edge
// RL8 - enable and disable command writes act in one access each
// RL9 - mask readback register shows the enable state
// RL10 - disabled sources never affect servicing of enabled ones
// RL11 - set and clear commands act on edge latches, source 0 included
// RL12 - set and clear commands ignore level-sensitive sources
// RL13 - vector read clears only the current source's edge latch
// RL14 - fast-forced sources are exempt from vector-read auto clear
// RL15 - fast vector read clears source 0's edge latch
// RL16 - pending register shows activity whether masked or not
// RL17 - current number register returns the serviced source number
// RL18 - core status register mirrors both request outputs
// RL19 - continuously clocked, unaffected by clock gating
// RL20 - either request output asserted wakes the processor
// RL21 - general mask wakes processor without asserting request
// RL22 - pin-multiplexed external lines see no extra latency
// RL23 - sources carry priority 7 highest down to 0 lowest
// RL24 - vector read picks highest priority, lowest number on ties
// RL25 - equal or lower priority waits for end of service
// RL26 - eight-deep stack pushed on vector read, popped on end
// RL27 - external lines synchronised before detection
`timescale 1ns/10ps
module vpic_ctrl
  import vpic_pkg::*;
#(
  parameter logic [NUM_SRC-1:0] EXT_SRC_MASK = 32'h0000_0001,
  parameter int                 SYS_LINES    = 4
) (
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst,
  // apb slave
  input  wire logic [ADDR_W-1:0]    paddr,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [31:0]          pwdata,
  output logic                      pready,
  output logic      [31:0]          prdata,
  output logic                      pslverr,
  // interrupt sources
  input  wire logic                 fastRequestInput,
  input  wire logic [SYS_LINES-1:0] systemIrqLines,
  input  wire logic [NUM_SRC-1:2]   peripheralIrq,
  input  wire logic [NUM_SRC-1:2]   externalRequestInputs,
  // processor side
  output logic                      normalRequestOut_n,
  output logic                      fastRequestOut_n,
  output logic                      wakeRequest
);

  // ==========================================================
  // elaboration checks
  if (!EXT_SRC_MASK[0] || EXT_SRC_MASK[1]) begin : g_bad_mask
    $error("source 0 must be external and source 1 internal");
  end
  if (SYS_LINES < 1) begin : g_bad_sys
    $error("at least one system line is needed");
  end

  typedef struct packed {
    logic [NUM_SRC-1:0][PRIO_W-1:0]     prio;
    logic [NUM_SRC-1:0][TRIG_W-1:0]     trig;
    logic [NUM_SRC-1:0][31:0]           vec;
    logic [31:0]                        spur;
    logic [NUM_SRC-1:0]                 enable;
    logic [NUM_SRC-1:0]                 ffEn;
    logic                               gmask;
    logic [NUM_SRC-1:0]                 latch;
    logic [NUM_SRC-1:0]                 rawPrev;
    logic [STACK_DEPTH-1:0][SRC_W-1:0]  stkNum;
    logic [STACK_DEPTH-1:0][PRIO_W-1:0] stkLvl;
    logic [DEPTH_W-1:0]                 depth;
    logic [SRC_W-1:0]                   ivrIdx;
    logic [PRIO_W-1:0]                  ivrPrio;
    logic                               ivrValid;
    logic                               irqN;
    logic                               fiqN;
    logic                               wake;
    logic                               pready;
    logic                               pslverr;
    logic [31:0]                        prdata;
  } vpic_state_s;

  vpic_state_s s_q;
  vpic_state_s s_d;

  function automatic logic isMapped(input logic [ADDR_W-1:0] a);
    logic hit;
    hit = (a[1:0] == 2'h0);
    case (a)
      IVR_OFS, FVR_OFS, CUR_OFS, PEND_OFS, MASK_OFS, CORE_OFS,
      ENA_OFS, DIS_OFS, CLR_OFS, SET_OFS, EOS_OFS, SPUR_OFS,
      DBG_OFS, FFEN_OFS, FFDIS_OFS, FFST_OFS: isMapped = hit;
      default: begin
        isMapped = hit && (a[ADDR_W-1:7] == MODE_BASE[ADDR_W-1:7] ||
                           a[ADDR_W-1:7] == VEC_BASE[ADDR_W-1:7]);
      end
    endcase
  endfunction : isMapped

  function automatic logic wrHit(input logic          w,
                                 input logic [ADDR_W-1:0] a,
                                 input logic [ADDR_W-1:0] ofs);
    wrHit = w && (a == ofs);
  endfunction : wrHit

  // ==========================================================
  // source collection
  logic [NUM_SRC-1:0] extSync;
  logic [NUM_SRC-1:0] raw;
  logic [NUM_SRC-1:0] pol;
  logic [NUM_SRC-1:0] act;
  logic [NUM_SRC-1:0] edgeSel;
  logic [NUM_SRC-1:0] edgeDet;
  logic [NUM_SRC-1:0] pending;
  logic [NUM_SRC-1:0] normCand;
  logic [NUM_SRC-1:0] fastCand;
  logic               candValid;
  logic [SRC_W-1:0]   candIdx;
  logic [PRIO_W-1:0]  candPrio;

  vpic_sync3 #(
    .W       (NUM_SRC)
  ) u_sync (
    .clk     (clk),
    .rst     (rst),
    .asyncIn ({externalRequestInputs, 1'b0, fastRequestInput}), // RL27 RL1
    .syncOut (extSync)
  );

  always_comb begin
    raw    = '0;
    raw[0] = extSync[0];                                        // RL1
    raw[1] = |systemIrqLines;                                   // RL2
    // same path for direct and multiplexed external lines
    for (int i = 2; i < NUM_SRC; i++) begin
      raw[i] = EXT_SRC_MASK[i] ? extSync[i] : peripheralIrq[i]; // RL3 RL4 RL22
    end
  end

  always_comb begin
    for (int i = 0; i < NUM_SRC; i++) begin
      edgeSel[i] = s_q.trig[i][0];                              // RL5 RL6
      pol[i]     = EXT_SRC_MASK[i] & ~s_q.trig[i][1];           // RL7
    end
  end

  assign act     = raw ^ pol;
  assign edgeDet = act & ~(s_q.rawPrev ^ pol) & edgeSel;
  assign pending = (edgeSel & s_q.latch) | (~edgeSel & act);    // RL16
  assign normCand = pending & s_q.enable & ~s_q.ffEn
                    & ~32'h0000_0001;                           // RL10
  assign fastCand = pending & s_q.enable & (s_q.ffEn | 32'h0000_0001);

  vpic_prio_sel u_sel (
    .cand     (normCand),
    .prio     (s_q.prio),                                       // RL23
    .winValid (candValid),
    .winIdx   (candIdx),                                        // RL24
    .winPrio  (candPrio)
  );

  // ==========================================================
  // bus phases
  logic               setup;
  logic               access;
  logic               wr;
  logic               rd;
  logic               ivrRd;
  logic               eosWr;
  logic [NUM_SRC-1:0] setCmd;
  logic [NUM_SRC-1:0] clrCmd;
  logic [NUM_SRC-1:0] autoClr;
  logic [31:0]        rdata;
  logic [SRC_W-1:0]   regIdx;

  assign setup  = psel && !penable;
  assign access = psel && penable && s_q.pready;
  assign wr     = access && pwrite;
  assign rd     = access && !pwrite;
  assign ivrRd  = rd && (paddr == IVR_OFS);
  assign eosWr  = wrHit(wr, paddr, EOS_OFS);
  assign regIdx = paddr[6:2];

  // ==========================================================
  // read mux, sampled in the setup cycle
  always_comb begin
    rdata = WORD_RST;
    case (paddr)
      IVR_OFS:   rdata = candValid ? s_q.vec[candIdx] : s_q.spur;
      FVR_OFS:   rdata = s_q.vec[0];
      CUR_OFS:   rdata = {27'h0000000, s_q.stkNum[0]};          // RL17
      PEND_OFS:  rdata = pending;                               // RL16
      MASK_OFS:  rdata = s_q.enable;                            // RL9
      CORE_OFS:  rdata = {30'h00000000, ~s_q.fiqN, ~s_q.irqN};  // RL18
      SPUR_OFS:  rdata = s_q.spur;
      DBG_OFS:   rdata = {30'h00000000, s_q.gmask, 1'b0};
      FFST_OFS:  rdata = s_q.ffEn;
      default: begin
        if (paddr[ADDR_W-1:7] == MODE_BASE[ADDR_W-1:7]) begin
          rdata = {25'h0000000, s_q.trig[regIdx], 2'h0, s_q.prio[regIdx]};
        end else if (paddr[ADDR_W-1:7] == VEC_BASE[ADDR_W-1:7]) begin
          rdata = s_q.vec[regIdx];
        end
      end
    endcase
  end

  // ==========================================================
  // next state
  always_comb begin
    s_d         = s_q;
    s_d.rawPrev = raw;
    setCmd      = wrHit(wr, paddr, SET_OFS) ? pwdata : '0;      // RL11
    clrCmd      = wrHit(wr, paddr, CLR_OFS) ? pwdata : '0;      // RL11
    autoClr     = '0;
    if (ivrRd && s_q.ivrValid && !s_q.ffEn[s_q.ivrIdx]) begin
      autoClr[s_q.ivrIdx] = 1'b1;                               // RL13 RL14
    end
    if (rd && paddr == FVR_OFS) begin
      autoClr[0] = 1'b1;                                        // RL15
    end
    // a new edge beats a same-cycle clear; level sources hold no latch
    s_d.latch = ((s_q.latch & ~(clrCmd | autoClr)) | edgeDet | setCmd)
                & edgeSel;                                      // RL12

    if (wr && paddr[ADDR_W-1:7] == MODE_BASE[ADDR_W-1:7]) begin
      s_d.prio[regIdx] = pwdata[MODE_PRIO_LSB +: PRIO_W];       // RL23
      s_d.trig[regIdx] = pwdata[MODE_TRIG_LSB +: TRIG_W];       // RL5
    end
    if (wr && paddr[ADDR_W-1:7] == VEC_BASE[ADDR_W-1:7]) begin
      s_d.vec[regIdx] = pwdata;
    end
    if (wrHit(wr, paddr, ENA_OFS)) begin
      s_d.enable = s_q.enable | pwdata;                         // RL8
    end
    if (wrHit(wr, paddr, DIS_OFS)) begin
      s_d.enable = s_q.enable & ~pwdata;                        // RL8
    end
    if (wrHit(wr, paddr, FFEN_OFS)) begin
      s_d.ffEn = (s_q.ffEn | pwdata) & ~32'h0000_0001;
    end
    if (wrHit(wr, paddr, FFDIS_OFS)) begin
      s_d.ffEn = s_q.ffEn & ~pwdata;
    end
    if (wrHit(wr, paddr, SPUR_OFS)) begin
      s_d.spur = pwdata;
    end
    if (wrHit(wr, paddr, DBG_OFS)) begin
      s_d.gmask = pwdata[DBG_GMASK_BIT];
    end

    // nesting stack, top at index 0; a push when full drops the bottom
    if (ivrRd && s_q.ivrValid) begin
      for (int k = STACK_DEPTH - 1; k > 0; k--) begin
        s_d.stkNum[k] = s_q.stkNum[k-1];
        s_d.stkLvl[k] = s_q.stkLvl[k-1];
      end
      s_d.stkNum[0] = s_q.ivrIdx;                               // RL26
      s_d.stkLvl[0] = s_q.ivrPrio;
      if (s_q.depth != DEPTH_W'(STACK_DEPTH)) begin
        s_d.depth = s_q.depth + 4'h1;
      end
    end else if (eosWr && s_q.depth != 4'h0) begin
      for (int k = 0; k < STACK_DEPTH - 1; k++) begin
        s_d.stkNum[k] = s_q.stkNum[k+1];
        s_d.stkLvl[k] = s_q.stkLvl[k+1];
      end
      s_d.stkNum[STACK_DEPTH-1] = '0;
      s_d.stkLvl[STACK_DEPTH-1] = '0;
      s_d.depth = s_q.depth - 4'h1;                             // RL26
    end

    // only a strictly higher priority re-raises the normal line
    s_d.irqN = !(candValid && !s_q.gmask &&
                 (s_q.depth == 4'h0 || candPrio > s_q.stkLvl[0])); // RL25
    s_d.fiqN = !((|fastCand) && !s_q.gmask);
    s_d.wake = |(pending & s_q.enable);                         // RL20 RL21

    s_d.pready  = setup;
    s_d.pslverr = setup && !isMapped(paddr);
    if (setup) begin
      s_d.prdata   = rdata;
      s_d.ivrIdx   = candIdx;                                   // RL24
      s_d.ivrPrio  = candPrio;
      s_d.ivrValid = candValid;
    end
  end

  // free-running clock, no gating enable anywhere
  always_ff @(posedge clk) begin                                // RL19
    if (rst) begin
      s_q      <= '0;
      s_q.irqN <= 1'b1;
      s_q.fiqN <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign pready             = s_q.pready;
  assign prdata             = s_q.prdata;
  assign pslverr            = s_q.pslverr;
  assign normalRequestOut_n = s_q.irqN;
  assign fastRequestOut_n   = s_q.fiqN;
  assign wakeRequest        = s_q.wake;

  // ==========================================================
  // assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence apbWrite(logic [ADDR_W-1:0] ofs);
    wr && paddr == ofs;
  endsequence

  sequence ivrTaken;
    ivrRd && s_q.ivrValid && s_q.depth != DEPTH_W'(STACK_DEPTH);
  endsequence

  enable_cmd_a: assert property (apbWrite(ENA_OFS) |=>    // RL8
    (s_q.enable & $past(pwdata)) == $past(pwdata))
    else $error("enable command did not set mask bits");

  disable_cmd_a: assert property (apbWrite(DIS_OFS) |=>   // RL8
    (s_q.enable & $past(pwdata)) == 32'h0000_0000)
    else $error("disable command did not clear mask bits");

  level_no_latch_a: assert property (                     // RL12
    (s_q.latch & ~$past(edgeSel)) == 32'h0000_0000)
    else $error("level source holds an edge latch");

  ivr_autoclr_a: assert property (                        // RL13
    ivrRd && s_q.ivrValid && !s_q.ffEn[s_q.ivrIdx] &&
    !edgeDet[s_q.ivrIdx] && !setCmd[s_q.ivrIdx] |=>
    !s_q.latch[s_q.ivrIdx])
    else $error("vector read left current latch set");

  fvr_autoclr_a: assert property (                        // RL15
    rd && paddr == FVR_OFS && !edgeDet[0] |=> !s_q.latch[0])
    else $error("fast vector read did not clear source 0");

  stack_push_a: assert property (ivrTaken |=>             // RL26
    s_q.depth == $past(s_q.depth) + 4'h1 &&
    s_q.stkNum[0] == $past(s_q.ivrIdx))
    else $error("vector read did not push stack");

  stack_pop_a: assert property (                          // RL26
    apbWrite(EOS_OFS) ##0 s_q.depth != 4'h0 |=>
    s_q.depth == $past(s_q.depth) - 4'h1)
    else $error("end of service did not pop stack");

  core_status_a: assert property (setup && paddr == CORE_OFS |=> // RL18
    s_q.prdata[1:0] == {~$past(s_q.fiqN), ~$past(s_q.irqN)})
    else $error("core status differs from request lines");

  nest_hold_a: assert property (                          // RL25
    s_q.depth != 4'h0 && candValid && candPrio <= s_q.stkLvl[0]
    |=> normalRequestOut_n)
    else $error("equal or lower priority raised request");

  gmask_wake_a: assert property (                         // RL21
    s_q.gmask && |(pending & s_q.enable)
    |=> wakeRequest && normalRequestOut_n && fastRequestOut_n)
    else $error("general mask failed wake without request");

endmodule : vpic_ctrl

// [vpic_pkg.sv]
// Purpose: shared constants for the vectored priority interrupt controller
// Assumes: 32 sources, 32-bit APB data, 12-bit byte address
// Notes:   register words are aligned; offsets are byte addresses
package vpic_pkg;

  // ==========================================================
  // sizes
  localparam int NUM_SRC     = 32;
  localparam int SRC_W       = 5;
  localparam int PRIO_W      = 3;
  localparam int TRIG_W      = 2;
  localparam int ADDR_W      = 12;
  localparam int STACK_DEPTH = 8;
  localparam int DEPTH_W     = 4;

  // ==========================================================
  // register offsets
  localparam logic [ADDR_W-1:0] MODE_BASE = 12'h000;
  localparam logic [ADDR_W-1:0] VEC_BASE  = 12'h080;
  localparam logic [ADDR_W-1:0] IVR_OFS   = 12'h100;
  localparam logic [ADDR_W-1:0] FVR_OFS   = 12'h104;
  localparam logic [ADDR_W-1:0] CUR_OFS   = 12'h108;
  localparam logic [ADDR_W-1:0] PEND_OFS  = 12'h10C;
  localparam logic [ADDR_W-1:0] MASK_OFS  = 12'h110;
  localparam logic [ADDR_W-1:0] CORE_OFS  = 12'h114;
  localparam logic [ADDR_W-1:0] ENA_OFS   = 12'h120;
  localparam logic [ADDR_W-1:0] DIS_OFS   = 12'h124;
  localparam logic [ADDR_W-1:0] CLR_OFS   = 12'h128;
  localparam logic [ADDR_W-1:0] SET_OFS   = 12'h12C;
  localparam logic [ADDR_W-1:0] EOS_OFS   = 12'h130;
  localparam logic [ADDR_W-1:0] SPUR_OFS  = 12'h134;
  localparam logic [ADDR_W-1:0] DBG_OFS   = 12'h138;
  localparam logic [ADDR_W-1:0] FFEN_OFS  = 12'h140;
  localparam logic [ADDR_W-1:0] FFDIS_OFS = 12'h144;
  localparam logic [ADDR_W-1:0] FFST_OFS  = 12'h148;

  // ==========================================================
  // field positions
  localparam int MODE_PRIO_LSB = 0;
  localparam int MODE_TRIG_LSB = 5;
  localparam int DBG_GMASK_BIT = 1;

  // ==========================================================
  // trigger encodings; bit 0 selects edge, bit 1 selects high/rising
  localparam logic [TRIG_W-1:0] TRIG_LVL_LOW   = 2'h0;
  localparam logic [TRIG_W-1:0] TRIG_EDGE_FALL = 2'h1;
  localparam logic [TRIG_W-1:0] TRIG_LVL_HIGH  = 2'h2;
  localparam logic [TRIG_W-1:0] TRIG_EDGE_RISE = 2'h3;

  // ==========================================================
  // reset values
  localparam logic [31:0] WORD_RST = 32'h0000_0000;

endpackage : vpic_pkg

// [vpic_sync3.sv]
// Purpose: three-stage input synchroniser with agreement filter
// Assumes: inputs are asynchronous to clk
// Notes:   output follows once stages two and three agree
`timescale 1ns/10ps
module vpic_sync3 #(
  parameter int W = 32
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // data
  input  wire logic [W-1:0] asyncIn,
  output logic      [W-1:0] syncOut
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] out;
  } vpic_sync_s;

  vpic_sync_s s_q;
  vpic_sync_s s_d;

  // ==========================================================
  // next state
  always_comb begin
    s_d     = s_q;
    s_d.s1  = asyncIn;
    s_d.s2  = s_q.s1;
    s_d.s3  = s_q.s2;
    s_d.out = (~(s_q.s2 ^ s_q.s3) & s_q.s3) | ((s_q.s2 ^ s_q.s3) & s_q.out);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign syncOut = s_q.out;

endmodule : vpic_sync3

// [vpic_prio_sel.sv]
// Purpose: picks the highest-priority candidate source
// Assumes: candidates already masked and filtered
// Notes:   equal priorities resolve to the lowest source number
`timescale 1ns/10ps
module vpic_prio_sel
  import vpic_pkg::*;
(
  // candidates
  input  wire logic [NUM_SRC-1:0]             cand,
  input  wire logic [NUM_SRC-1:0][PRIO_W-1:0] prio,
  // winner
  output logic                                winValid,
  output logic      [SRC_W-1:0]               winIdx,
  output logic      [PRIO_W-1:0]              winPrio
);

  // ==========================================================
  // scan downward so a tie keeps the lower number
  always_comb begin
    winValid = 1'b0;
    winIdx   = '0;
    winPrio  = '0;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (cand[i] && (!winValid || prio[i] >= winPrio)) begin
        winValid = 1'b1;
        winIdx   = SRC_W'(i);
        winPrio  = prio[i];
      end
    end
  end

endmodule : vpic_prio_sel

// [vpic_cpu_model.sv]
// Purpose: processor core stand-in that sleeps and wakes
// Assumes: request lines active low, wake line active high
// Notes:   idle is left on any request or wake event
`timescale 1ns/10ps
module vpic_cpu_model (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // bench control
  input  wire logic goIdle,
  // controller lines
  input  wire logic normalRequestOut_n,
  input  wire logic fastRequestOut_n,
  input  wire logic wakeRequest,
  // core state
  output logic      idle
);
  always_ff @(posedge clk) begin
    if (rst) begin
      idle <= 1'b0;
    end else if (!normalRequestOut_n || !fastRequestOut_n) begin
      idle <= 1'b0;
    end else if (wakeRequest) begin
      idle <= 1'b0;
    end else if (goIdle) begin
      idle <= 1'b1;
    end
  end
endmodule : vpic_cpu_model

// [tb_top.sv]
// Purpose: self-checking bench for the interrupt controller
// Assumes: zero-wait APB slave, source 4 wired as an external line
// Notes:   random vectors and enables from a fixed seed
`timescale 1ns/10ps
module tb_top
  import vpic_pkg::*;
;
  localparam logic [NUM_SRC-1:0] EXT_MASK = 32'h0000_0011;
  logic               clk, rst, psel, penable, pwrite, pready, pslverr;
  logic [ADDR_W-1:0]  paddr;
  logic [31:0]        pwdata, prdata, r, m, spur;
  logic [31:0]        vec [NUM_SRC];
  logic               fastRequestInput, normalRequestOut_n;
  logic               fastRequestOut_n, wakeRequest, goIdle, idle, errSeen;
  logic [3:0]         systemIrqLines;
  logic [NUM_SRC-1:2] peripheralIrq, externalRequestInputs;
  logic [1:0]         t;
  int                 n_mismatch, cmp_count, seed;

  vpic_ctrl #(.EXT_SRC_MASK(EXT_MASK), .SYS_LINES(4)) i_vpic_ctrl (
    .clk(clk), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .fastRequestInput(fastRequestInput),
    .systemIrqLines(systemIrqLines), .peripheralIrq(peripheralIrq),
    .externalRequestInputs(externalRequestInputs),
    .normalRequestOut_n(normalRequestOut_n),
    .fastRequestOut_n(fastRequestOut_n), .wakeRequest(wakeRequest));

  vpic_cpu_model i_vpic_cpu_model (
    .clk(clk), .rst(rst), .goIdle(goIdle),
    .normalRequestOut_n(normalRequestOut_n),
    .fastRequestOut_n(fastRequestOut_n), .wakeRequest(wakeRequest),
    .idle(idle));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // ==========================================
  // bus and check tasks
  task automatic apb(input logic w, input logic [ADDR_W-1:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) n_mismatch++;
    r = prdata;
    errSeen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rdc(input logic [ADDR_W-1:0] a, input logic [31:0] e);
    apb(1'b0, a, WORD_RST);
    chk(r, e);
  endtask : rdc

  task automatic setMode(input int n, input logic [1:0] tr,
                         input logic [2:0] p);
    wr(MODE_BASE + 12'(4 * n),
       (32'(tr) << MODE_TRIG_LSB) | (32'(p) << MODE_PRIO_LSB));
  endtask : setMode

  task automatic give_verdict();
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : give_verdict

  initial begin : watchdog
    repeat (20000) @(posedge clk);
    n_mismatch++;
    give_verdict();
  end

  // ==========================================
  // main sequence
  initial begin : main
    seed = 32'h083E;
    {psel, penable, pwrite, fastRequestInput, goIdle} = '0;
    {paddr, pwdata, systemIrqLines} = '0;
    {peripheralIrq, externalRequestInputs} = '0;
    n_mismatch = 0;
    cmp_count = 0;
    rst = 1'b1;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    rdc(MASK_OFS, WORD_RST);
    rdc(PEND_OFS, EXT_MASK);
    rdc(CORE_OFS, WORD_RST);
    rdc(CUR_OFS, WORD_RST);
    // external lines idle low, so park them as active-high levels
    setMode(0, TRIG_LVL_HIGH, 3'h0);
    setMode(4, TRIG_LVL_HIGH, 3'h0);
    rdc(PEND_OFS, WORD_RST);
    apb(1'b0, 12'h200, WORD_RST);
    chk(32'(errSeen), 32'h1);
    m = $random(seed) | 32'h1;
    wr(ENA_OFS, m);
    rdc(MASK_OFS, m);
    wr(DIS_OFS, m);
    rdc(MASK_OFS, WORD_RST);
    for (int i = 0; i < NUM_SRC; i++) begin
      vec[i] = $random(seed);
      wr(VEC_BASE + 12'(4 * i), vec[i]);
    end
    spur = $random(seed);
    wr(SPUR_OFS, spur);
    // edge latch on an internal source
    setMode(5, TRIG_EDGE_RISE, 3'h3);
    wr(ENA_OFS, 32'h0000_0020);
    peripheralIrq[5] <= 1'b1;
    @(posedge clk);
    peripheralIrq[5] <= 1'b0;
    rdc(PEND_OFS, 32'h0000_0020);
    rdc(CORE_OFS, 32'h0000_0001);
    rdc(IVR_OFS, vec[5]);
    rdc(CUR_OFS, 32'h0000_0005);
    rdc(PEND_OFS, WORD_RST);
    wr(EOS_OFS, WORD_RST);
    // priority, ties, nesting, disabled source
    setMode(6, TRIG_EDGE_RISE, 3'h2);
    setMode(7, TRIG_EDGE_RISE, 3'h2);
    setMode(9, TRIG_EDGE_RISE, 3'h5);
    setMode(12, TRIG_EDGE_RISE, 3'h7);
    wr(ENA_OFS, 32'h0000_02C0);
    wr(SET_OFS, 32'h0000_12C0);
    rdc(PEND_OFS, 32'h0000_12C0);
    rdc(IVR_OFS, vec[9]);
    repeat (2) @(posedge clk);
    chk(32'(normalRequestOut_n), 32'h1);
    wr(EOS_OFS, WORD_RST);
    repeat (2) @(posedge clk);
    chk(32'(normalRequestOut_n), 32'h0);
    rdc(IVR_OFS, vec[6]);
    wr(EOS_OFS, WORD_RST);
    rdc(IVR_OFS, vec[7]);
    wr(SET_OFS, 32'h0000_0200);
    rdc(IVR_OFS, vec[9]);
    rdc(CUR_OFS, 32'h0000_0009);
    wr(EOS_OFS, WORD_RST);
    rdc(CUR_OFS, 32'h0000_0007);
    wr(EOS_OFS, WORD_RST);
    rdc(IVR_OFS, spur);
    wr(CLR_OFS, 32'h0000_1000);
    rdc(PEND_OFS, WORD_RST);
    setMode(10, TRIG_LVL_HIGH, 3'h1);
    wr(SET_OFS, 32'h0000_0400);
    rdc(PEND_OFS, WORD_RST);
    // system group source
    setMode(1, TRIG_LVL_HIGH, 3'h1);
    for (int k = 0; k < 4; k++) begin
      systemIrqLines <= 4'(1 << k);
      rdc(PEND_OFS, 32'h0000_0002);
      systemIrqLines <= 4'h0;
      rdc(PEND_OFS, WORD_RST);
    end
    // external source in all four trigger modes
    for (int k = 0; k < 4; k++) begin
      t = 2'(k);
      externalRequestInputs[4] <= ~t[1];
      repeat (6) @(posedge clk);
      setMode(4, t, 3'h1);
      wr(CLR_OFS, 32'h0000_0010);
      rdc(PEND_OFS, WORD_RST);
      externalRequestInputs[4] <= t[1];
      repeat (6) @(posedge clk);
      rdc(PEND_OFS, 32'h0000_0010);
      externalRequestInputs[4] <= ~t[1];
      repeat (6) @(posedge clk);
      rdc(PEND_OFS, {27'h0, t[0], 4'h0});
      wr(CLR_OFS, 32'h0000_0010);
    end
    // fast source and fast forcing
    setMode(0, TRIG_EDGE_RISE, 3'h0);
    wr(ENA_OFS, 32'h0000_0001);
    fastRequestInput <= 1'b1;
    repeat (8) @(posedge clk);
    fastRequestInput <= 1'b0;
    chk(32'(fastRequestOut_n), 32'h0);
    rdc(CORE_OFS, 32'h0000_0002);
    rdc(FVR_OFS, vec[0]);
    rdc(PEND_OFS, WORD_RST);
    rdc(CORE_OFS, WORD_RST);
    setMode(8, TRIG_EDGE_RISE, 3'h4);
    wr(FFEN_OFS, 32'h0000_0100);
    wr(ENA_OFS, 32'h0000_0100);
    wr(SET_OFS, 32'h0000_0100);
    rdc(CORE_OFS, 32'h0000_0002);
    rdc(IVR_OFS, spur);
    rdc(PEND_OFS, 32'h0000_0100);
    wr(FFDIS_OFS, 32'h0000_0100);
    wr(DIS_OFS, 32'h0000_0100);
    wr(CLR_OFS, 32'h0000_0100);
    // wake under the general mask
    goIdle <= 1'b1;
    @(posedge clk);
    goIdle <= 1'b0;
    wr(DBG_OFS, 32'h0000_0002);
    chk(32'(idle), 32'h1);
    wr(SET_OFS, 32'h0000_0020);
    repeat (3) @(posedge clk);
    chk(32'(idle), 32'h0);
    chk(32'(normalRequestOut_n), 32'h1);
    chk(32'(wakeRequest), 32'h1);
    wr(DBG_OFS, WORD_RST);
    repeat (2) @(posedge clk);
    chk(32'(normalRequestOut_n), 32'h0);
    rdc(IVR_OFS, vec[5]);
    wr(EOS_OFS, WORD_RST);
    give_verdict();
  end
endmodule : tb_top
